// ### gpt_timers.v
`include "gpt_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module gpt_timers (
	input  wire       core_clk,
	input  wire       srst,
	input  wire [7:0] sfr_addr,
	input  wire [7:0] sfr_wdata,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	output wire [7:0] sfr_rdata,
	input  wire       timer0_count_pin,
	input  wire       timer1_count_pin,
	input  wire       ext_osc_div8,
	input  wire       ext_irq0_input,
	input  wire       ext_irq1_input,
	input  wire       ext_irq0_polarity,
	input  wire       ext_irq1_polarity,
	input  wire       timer0_clock_select,
	input  wire       timer1_clock_select,
	input  wire       timer2_high_clock_select,
	input  wire       timer2_low_clock_select,
	input  wire       timer2_irq_enable,
	output wire       timer0_irq,
	output wire       timer1_irq,
	output wire       timer2_irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [7:0] rdata_r;
	reg [7:0] timer01_mode_config_r;
	reg [7:0] tl0_r, th0_r, tl1_r, th1_r;
	reg [7:0] t2l_r, t2h_r, t2rll_r, t2rlh_r;
	reg       tf0_r, tf1_r, tr0_r, tr1_r;
	reg       timer2_high_overflow_flag_r, timer2_low_overflow_flag_r, t2len_r, t2cen_r, timer2_split_select_r, tr2_r, timer2_ext_clock_select_r;
	reg       t2irq_r;
	reg [3:0] pre_cnt_r;
	reg       pre_tick_r;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	wire [`GPT_NUM_SYNC-1:0] raw_in;
	wire [`GPT_NUM_SYNC-1:0] sync_lvl;
	wire [`GPT_NUM_SYNC-1:0] sync_fall;

	assign raw_in = {ext_irq1_input, ext_irq0_input, ext_osc_div8, timer1_count_pin, timer0_count_pin};

	genvar gi;
	generate
		for (gi = 0; gi < `GPT_NUM_SYNC; gi = gi + 1) begin : g_sync
			gpt_sync_edge u_sync (
				.core_clk   (core_clk),
				.srst       (srst),
				.async_in   (raw_in[gi]),
				.level_out  (sync_lvl[gi]),
				.fall_pulse (sync_fall[gi])
			);
		end
	endgenerate

	wire t0_pin_fall = sync_fall[0];
	wire t1_pin_fall = sync_fall[1];
	wire ext_fall    = sync_fall[2];
	wire irq0_active = (sync_lvl[3] == ext_irq0_polarity);
	wire irq1_active = (sync_lvl[4] == ext_irq1_polarity);

	// ----------------------------------------------------------------
	// system clock divided by 12
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		if (srst) begin
			pre_cnt_r  <= `GPT_PRE_ZERO;
			pre_tick_r <= 1'b0;
		end else begin
			pre_tick_r <= (pre_cnt_r == `GPT_PRE_LAST);
			if (pre_cnt_r == `GPT_PRE_LAST)
				pre_cnt_r <= `GPT_PRE_ZERO;
			else
				pre_cnt_r <= pre_cnt_r + `GPT_PRE_ONE;
		end
	end

	// ----------------------------------------------------------------
	// timer 0 / timer 1 control decode
	// ----------------------------------------------------------------
	wire       timer1_gating_enable = timer01_mode_config_r[`GPT_TIMER01_MODE_CONFIG_TIMER1_GATING_ENABLE];
	wire       ct1   = timer01_mode_config_r[`GPT_TIMER01_MODE_CONFIG_CT1];
	wire [1:0] t1m   = timer01_mode_config_r[`GPT_TIMER01_MODE_CONFIG_M1_HI:`GPT_TIMER01_MODE_CONFIG_M1_LO];
	wire       timer0_gating_enable = timer01_mode_config_r[`GPT_TIMER01_MODE_CONFIG_TIMER0_GATING_ENABLE];
	wire       ct0   = timer01_mode_config_r[`GPT_TIMER01_MODE_CONFIG_CT0];
	wire [1:0] t0m   = timer01_mode_config_r[`GPT_TIMER01_MODE_CONFIG_M0_HI:`GPT_TIMER01_MODE_CONFIG_M0_LO];
	wire       t0_split = (t0m == `GPT_MODE_SPLIT);

	wire tbase0 = timer0_clock_select | pre_tick_r;
	wire tbase1 = timer1_clock_select | pre_tick_r;
	wire tick0  = ct0 ? t0_pin_fall : tbase0;
	wire tick1  = ct1 ? t1_pin_fall : tbase1;
	wire run0   = tr0_r & (~timer0_gating_enable | irq0_active);
	wire run1   = tr1_r & (~timer1_gating_enable | irq1_active);
	wire inc0   = run0 & tick0;
	// with timer 0 split, timer 1 has no external clock and runs by mode alone
	wire inc1   = t0_split ? tbase1 : (run1 & tick1);

	// {overflow, high, low} after one count in modes 0 to 2
	function [16:0] gpt_step;
		input [1:0] mode;
		input [7:0] lo;
		input [7:0] hi;
		reg   [12:0] c13;
		reg   [15:0] c16;
		begin
			c13 = {hi, lo[4:0]};
			c16 = {hi, lo};
			case (mode)
				`GPT_MODE_13BIT: begin
					c13 = c13 + `GPT_M13_ONE;
					gpt_step = {({hi, lo[4:0]} == `GPT_M13_MAX), c13[12:5], lo[7:5], c13[4:0]};
				end
				`GPT_MODE_16BIT: begin
					c16 = c16 + `GPT_WORD_ONE;
					gpt_step = {({hi, lo} == `GPT_WORD_MAX), c16};
				end
				`GPT_MODE_RELOAD8: begin
					if (lo == `GPT_BYTE_MAX)
						gpt_step = {1'b1, hi, hi};
					else
						gpt_step = {1'b0, hi, lo + `GPT_BYTE_ONE};
				end
				default: gpt_step = {1'b0, hi, lo};
			endcase
		end
	endfunction

	reg [7:0]  tl0_nxt, th0_nxt, tl1_nxt, th1_nxt;
	reg        tf0_set, tf1_set;
	reg [16:0] step0, step1;

	always @* begin
		tl0_nxt = tl0_r;
		th0_nxt = th0_r;
		tl1_nxt = tl1_r;
		th1_nxt = th1_r;
		tf0_set = 1'b0;
		tf1_set = 1'b0;
		step0   = gpt_step(t0m, tl0_r, th0_r);
		step1   = gpt_step(t1m, tl1_r, th1_r);
		if (t0_split) begin
			if (inc0) begin
				tl0_nxt = tl0_r + `GPT_BYTE_ONE;
				tf0_set = (tl0_r == `GPT_BYTE_MAX);
			end
			if (tr1_r & tbase0) begin
				th0_nxt = th0_r + `GPT_BYTE_ONE;
				tf1_set = (th0_r == `GPT_BYTE_MAX);
			end
		end else if (inc0) begin
			tl0_nxt = step0[7:0];
			th0_nxt = step0[15:8];
			tf0_set = step0[16];
		end
		if ((t1m != `GPT_MODE_SPLIT) && inc1) begin
			tl1_nxt = step1[7:0];
			th1_nxt = step1[15:8];
			if (!t0_split)
				tf1_set = step1[16];
		end
	end

	// ----------------------------------------------------------------
	// timer 2
	// ----------------------------------------------------------------
	// per-byte clock choice
	wire t2_slow  = timer2_ext_clock_select_r ? ext_fall : pre_tick_r;
	wire t2_tickl = timer2_low_clock_select | t2_slow;
	wire t2_tickh = timer2_high_clock_select | t2_slow;
	wire capture  = t2cen_r & ext_fall;

	reg [7:0]  t2l_nxt, t2h_nxt, t2rll_nxt, t2rlh_nxt;
	reg        t2h_set, t2l_set;
	reg [15:0] t2_inc;

	always @* begin
		t2l_nxt   = t2l_r;
		t2h_nxt   = t2h_r;
		t2rll_nxt = t2rll_r;
		t2rlh_nxt = t2rlh_r;
		t2h_set   = 1'b0;
		t2l_set   = 1'b0;
		t2_inc    = {t2h_r, t2l_r} + `GPT_WORD_ONE;
		if (timer2_split_select_r) begin
			if (t2_tickl) begin
				t2l_set = (t2l_r == `GPT_BYTE_MAX);
				t2l_nxt = t2l_set ? t2rll_r : t2l_r + `GPT_BYTE_ONE;
			end
			if (tr2_r & t2_tickh) begin
				t2h_set = (t2h_r == `GPT_BYTE_MAX);
				t2h_nxt = t2h_set ? t2rlh_r : t2h_r + `GPT_BYTE_ONE;
			end
		end else if (tr2_r & t2_tickl) begin
			t2l_set = (t2l_r == `GPT_BYTE_MAX);
			if ({t2h_r, t2l_r} == `GPT_WORD_MAX) begin
				t2h_set = 1'b1;
				t2l_nxt = t2rll_r;
				t2h_nxt = t2rlh_r;
			end else begin
				t2l_nxt = t2_inc[7:0];
				t2h_nxt = t2_inc[15:8];
			end
		end
		if (capture) begin
			t2rll_nxt = t2l_r;
			t2rlh_nxt = t2h_r;
			t2h_set   = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// register file: a bus write wins over counting, a hardware
	// flag set wins over a software clear in the same cycle
	// ----------------------------------------------------------------
	wire wr_tcon = sfr_wr & (sfr_addr == `GPT_ADDR_TCON);
	wire wr_t2c  = sfr_wr & (sfr_addr == `GPT_ADDR_T2CTRL);

	always @(posedge core_clk) begin
		if (srst) begin
			timer01_mode_config_r <= `GPT_BYTE_RST;
			tl0_r <= `GPT_BYTE_RST;
			th0_r <= `GPT_BYTE_RST;
			tl1_r <= `GPT_BYTE_RST;
			th1_r <= `GPT_BYTE_RST;
			t2l_r <= `GPT_BYTE_RST;
			t2h_r <= `GPT_BYTE_RST;
			t2rll_r <= `GPT_BYTE_RST;
			t2rlh_r <= `GPT_BYTE_RST;
			tf0_r <= 1'b0;
			tf1_r <= 1'b0;
			tr0_r <= 1'b0;
			tr1_r <= 1'b0;
			timer2_high_overflow_flag_r <= 1'b0;
			timer2_low_overflow_flag_r <= 1'b0;
			t2len_r <= 1'b0;
			t2cen_r <= 1'b0;
			timer2_split_select_r <= 1'b0;
			tr2_r <= 1'b0;
			timer2_ext_clock_select_r <= 1'b0;
		end else begin
			if (sfr_wr && sfr_addr == `GPT_ADDR_TIMER01_MODE_CONFIG)
				timer01_mode_config_r <= sfr_wdata;
			tl0_r <= (sfr_wr && sfr_addr == `GPT_ADDR_TL0) ? sfr_wdata : tl0_nxt;
			th0_r <= (sfr_wr && sfr_addr == `GPT_ADDR_TH0) ? sfr_wdata : th0_nxt;
			tl1_r <= (sfr_wr && sfr_addr == `GPT_ADDR_TL1) ? sfr_wdata : tl1_nxt;
			th1_r <= (sfr_wr && sfr_addr == `GPT_ADDR_TH1) ? sfr_wdata : th1_nxt;
			t2l_r <= (sfr_wr && sfr_addr == `GPT_ADDR_T2L) ? sfr_wdata : t2l_nxt;
			t2h_r <= (sfr_wr && sfr_addr == `GPT_ADDR_T2H) ? sfr_wdata : t2h_nxt;
			t2rll_r <= (sfr_wr && sfr_addr == `GPT_ADDR_T2RLL) ? sfr_wdata : t2rll_nxt;
			t2rlh_r <= (sfr_wr && sfr_addr == `GPT_ADDR_T2RLH) ? sfr_wdata : t2rlh_nxt;
			tf0_r <= tf0_set | (wr_tcon ? sfr_wdata[`GPT_TCON_TF0] : tf0_r);
			tf1_r <= tf1_set | (wr_tcon ? sfr_wdata[`GPT_TCON_TF1] : tf1_r);
			if (wr_tcon) begin
				tr0_r <= sfr_wdata[`GPT_TCON_TR0];
				tr1_r <= sfr_wdata[`GPT_TCON_TR1];
			end
			// only a software write can clear these
			timer2_high_overflow_flag_r <= t2h_set | (wr_t2c ? sfr_wdata[`GPT_T2_TFH] : timer2_high_overflow_flag_r);
			timer2_low_overflow_flag_r <= t2l_set | (wr_t2c ? sfr_wdata[`GPT_T2_TFL] : timer2_low_overflow_flag_r);
			if (wr_t2c) begin
				t2len_r   <= sfr_wdata[`GPT_T2_LEN];
				t2cen_r   <= sfr_wdata[`GPT_T2_CEN];
				timer2_split_select_r <= sfr_wdata[`GPT_T2_SPLIT];
				tr2_r     <= sfr_wdata[`GPT_T2_RUN];
				timer2_ext_clock_select_r  <= sfr_wdata[`GPT_T2_XCLK];
			end
		end
	end

	// ----------------------------------------------------------------
	// read port and interrupt request
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		if (srst) begin
			rdata_r <= `GPT_BYTE_RST;
			t2irq_r <= 1'b0;
		end else begin
			// enabled level request follows the high flag, and the low flag only with t2len_r set, one cycle behind
			t2irq_r <= timer2_irq_enable & (timer2_high_overflow_flag_r | (t2len_r & timer2_low_overflow_flag_r));
			if (sfr_rd) begin
				case (sfr_addr)
					`GPT_ADDR_TCON:   rdata_r <= {tf1_r, tr1_r, tf0_r, tr0_r, 4'h0};
					`GPT_ADDR_TIMER01_MODE_CONFIG:   rdata_r <= timer01_mode_config_r;
					`GPT_ADDR_TL0:    rdata_r <= tl0_r;
					`GPT_ADDR_TL1:    rdata_r <= tl1_r;
					`GPT_ADDR_TH0:    rdata_r <= th0_r;
					`GPT_ADDR_TH1:    rdata_r <= th1_r;
					`GPT_ADDR_T2CTRL: rdata_r <= {timer2_high_overflow_flag_r, timer2_low_overflow_flag_r, t2len_r, t2cen_r, timer2_split_select_r, tr2_r, 1'b0, timer2_ext_clock_select_r};
					`GPT_ADDR_T2RLL:  rdata_r <= t2rll_r;
					`GPT_ADDR_T2RLH:  rdata_r <= t2rlh_r;
					`GPT_ADDR_T2L:    rdata_r <= t2l_r;
					`GPT_ADDR_T2H:    rdata_r <= t2h_r;
					default:          rdata_r <= `GPT_BYTE_RST;
				endcase
			end
		end
	end

	assign sfr_rdata  = rdata_r;
	assign timer0_irq = tf0_r;
	assign timer1_irq = tf1_r;
	assign timer2_irq = t2irq_r;

endmodule // gpt_timers

`default_nettype wire

// ### gpt_consts.vh
`ifndef GPT_CONSTS_VH
`define GPT_CONSTS_VH

// ----------------------------------------------------------------
// register addresses on the special function register bus
// ----------------------------------------------------------------
`define GPT_ADDR_TCON       8'h88
`define GPT_ADDR_TIMER01_MODE_CONFIG       8'h89
`define GPT_ADDR_TL0        8'h8A
`define GPT_ADDR_TL1        8'h8B
`define GPT_ADDR_TH0        8'h8C
`define GPT_ADDR_TH1        8'h8D
`define GPT_ADDR_T2CTRL     8'hC8
`define GPT_ADDR_T2RLL      8'hCA
`define GPT_ADDR_T2RLH      8'hCB
`define GPT_ADDR_T2L        8'hCC
`define GPT_ADDR_T2H        8'hCD

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GPT_TCON_TF1        7
`define GPT_TCON_TR1        6
`define GPT_TCON_TF0        5
`define GPT_TCON_TR0        4
`define GPT_TIMER01_MODE_CONFIG_TIMER1_GATING_ENABLE      7
`define GPT_TIMER01_MODE_CONFIG_CT1        6
`define GPT_TIMER01_MODE_CONFIG_M1_HI      5
`define GPT_TIMER01_MODE_CONFIG_M1_LO      4
`define GPT_TIMER01_MODE_CONFIG_TIMER0_GATING_ENABLE      3
`define GPT_TIMER01_MODE_CONFIG_CT0        2
`define GPT_TIMER01_MODE_CONFIG_M0_HI      1
`define GPT_TIMER01_MODE_CONFIG_M0_LO      0
`define GPT_T2_TFH          7
`define GPT_T2_TFL          6
`define GPT_T2_LEN          5
`define GPT_T2_CEN          4
`define GPT_T2_SPLIT        3
`define GPT_T2_RUN          2
`define GPT_T2_XCLK         0

// ----------------------------------------------------------------
// modes, reset values, counts
// ----------------------------------------------------------------
`define GPT_MODE_13BIT      2'h0
`define GPT_MODE_16BIT      2'h1
`define GPT_MODE_RELOAD8    2'h2
`define GPT_MODE_SPLIT      2'h3
`define GPT_BYTE_RST        8'h00
`define GPT_BYTE_MAX        8'hFF
`define GPT_BYTE_ONE        8'h01
`define GPT_WORD_MAX        16'hFFFF
`define GPT_WORD_ONE        16'h0001
`define GPT_M13_MAX         13'h1FFF
`define GPT_M13_ONE         13'h0001
`define GPT_PRE_LAST        4'hB
`define GPT_PRE_ZERO        4'h0
`define GPT_PRE_ONE         4'h1
`define GPT_SYNC_IDLE       1'b1
`define GPT_NUM_SYNC        5

`endif

// ### gpt_sync_edge.v
`include "gpt_consts.vh"
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// two-flop synchroniser with falling edge detect
// ----------------------------------------------------------------
module gpt_sync_edge (
	input  wire core_clk,
	input  wire srst,
	input  wire async_in,
	output wire level_out,
	output wire fall_pulse
);

	reg meta_r;
	reg sync_r;
	reg prev_r;

	// idle high after reset so a held-high pin gives no false edge; a held-low pin gives one falling edge
	always @(posedge core_clk) begin
		if (srst) begin
			meta_r <= `GPT_SYNC_IDLE;
			sync_r <= `GPT_SYNC_IDLE;
			prev_r <= `GPT_SYNC_IDLE;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level_out  = sync_r;
	assign fall_pulse = prev_r & ~sync_r;

endmodule // gpt_sync_edge

`default_nettype wire

// ### gpt_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// far side: count pins and ext/8
// ------------------------------
module gpt_pins_model (
	input  wire logic core_clk,
	output logic      timer0_count_pin,
	output logic      timer1_count_pin,
	output logic      ext_osc_div8
);
	logic [2:0] pins = 3'h7;
	assign {ext_osc_div8, timer1_count_pin, timer0_count_pin} = pins;
	// three cycles each level, above the one-cycle minimum of the synchroniser
	task automatic pulse(input int i);
		@(negedge core_clk);
		pins[i] = 1'b0;
		repeat (3) @(negedge core_clk);
		pins[i] = 1'b1;
		repeat (3) @(negedge core_clk);
	endtask
endmodule // gpt_pins_model
`default_nettype wire

// ### gpt_timers_asserts.sv
`include "gpt_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module gpt_timers_asserts (
	input wire logic       core_clk,
	input wire logic       srst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       timer2_irq_enable,
	input wire logic       timer0_irq,
	input wire logic       timer1_irq,
	input wire logic       timer2_irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	wire logic unmapped = !(sfr_addr inside {8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD});
	wire logic wr_tcon = sfr_wr && sfr_addr == `GPT_ADDR_TCON;
	wire logic wr_t2c = sfr_wr && sfr_addr == `GPT_ADDR_T2CTRL;
	sequence s_mode_wr;
		sfr_wr && sfr_addr == `GPT_ADDR_TIMER01_MODE_CONFIG;
	endsequence
	sequence s_mode_rd;
		sfr_rd && sfr_addr == `GPT_ADDR_TIMER01_MODE_CONFIG && !sfr_wr;
	endsequence
	a_reset_clears: assert property ($fell(srst) |-> sfr_rdata == 8'h00 && !timer0_irq && !timer1_irq && !timer2_irq)
		else $error("outputs not clear after reset");
	a_mode_wr_rd: assert property (s_mode_wr ##1 !sfr_wr ##1 s_mode_rd |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("mode register readback wrong");
	a_unmapped_zero: assert property (sfr_rd && unmapped |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_tcon_low_zero: assert property (sfr_rd && sfr_addr == `GPT_ADDR_TCON |=> sfr_rdata[3:0] == 4'h0)
		else $error("control low bits not zero");
	a_t2c_bit1_zero: assert property (sfr_rd && sfr_addr == `GPT_ADDR_T2CTRL |=> !sfr_rdata[1])
		else $error("timer 2 control bit 1 not zero");
	a_t2_irq_gated: assert property (!timer2_irq_enable |=> !timer2_irq)
		else $error("timer 2 irq while disabled");
	a_t2_flag_kept: assert property (timer2_irq && timer2_irq_enable && !wr_t2c && !$past(wr_t2c) |=> timer2_irq)
		else $error("timer 2 flag cleared by itself");
	a_t0_flag_kept: assert property (timer0_irq && !wr_tcon |=> timer0_irq)
		else $error("timer 0 flag cleared by itself");
endmodule // gpt_timers_asserts
bind gpt_timers gpt_timers_asserts i_gpt_timers_asserts (.core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr),
	.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
	.timer2_irq_enable(timer2_irq_enable), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq), .timer2_irq(timer2_irq));
`default_nettype wire

// ### tb.sv
`include "gpt_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic       core_clk = 0, srst = 1, sfr_wr = 0, sfr_rd = 0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v, th;
	logic       irq0 = 0, irq1 = 0, pol0 = 1, pol1 = 1, cs0 = 1, cs1 = 1, t2h = 1, t2l = 1, t2ie = 1;
	wire        p0, p1, osc, i0, i1, i2;
	wire  [7:0] sfr_rdata;
	logic [31:0] seed = 32'h54DF6342;
	int         miscompares = 0, n_compared = 0, cycles = 0;
	gpt_pins_model i_gpt_pins_model (.core_clk(core_clk), .timer0_count_pin(p0), .timer1_count_pin(p1), .ext_osc_div8(osc));
	gpt_timers i_gpt_timers (.core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer0_count_pin(p0), .timer1_count_pin(p1),
		.ext_osc_div8(osc), .ext_irq0_input(irq0), .ext_irq1_input(irq1), .ext_irq0_polarity(pol0),
		.ext_irq1_polarity(pol1), .timer0_clock_select(cs0), .timer1_clock_select(cs1),
		.timer2_high_clock_select(t2h), .timer2_low_clock_select(t2l), .timer2_irq_enable(t2ie),
		.timer0_irq(i0), .timer1_irq(i1), .timer2_irq(i2));
	initial forever #10 core_clk = ~core_clk;
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// 8-bit reload keeps the high byte; 13/16-bit wrap it to zero
	function automatic logic [7:0] exp_hi(input int m, input logic [7:0] h);
		return (m == 2) ? h : 8'h00;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1;
		@(negedge core_clk);
		sfr_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_rd = 1;
		@(negedge core_clk);
		sfr_rd = 0;
		d = sfr_rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	// low expectation waits the full span to prove the flag stays down
	task automatic wait_irq(input int k, input int n, input logic exp);
		logic [2:0] f;
		repeat (n) begin
			@(negedge core_clk);
			f = {i2, i1, i0};
			if (f[k] === 1'b1 && exp === 1'b1) break;
		end
		chk({7'h0, f[k]}, {7'h0, exp});
	endtask
	task automatic rst();
		srst = 1;
		repeat (2) @(negedge core_clk);
		srst = 0;
	endtask
	task automatic done(input string s);
		$display("test %0s done", s);
	endtask
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		repeat (6) @(negedge core_clk);
		srst = 0;
		for (int a = 8'h88; a <= 8'hCD; a += (a == 8'h8D) ? 59 : 1) rc(8'(a), 8'h00);
		for (int n = 0; n < 4; n++) for (int a = 8'h89; a <= 8'h8D; a++) begin
			th = rnd();
			// timer 0 split would let timer 1 run free and move the count bytes
			if (a == 8'h89) th[0] = th[0] & ~th[1];
			wr(8'(a), th);
			rc(8'(a), th);
		end
		wr(8'h42, rnd());
		rc(8'h42, 8'h00);
		done("registers");
		for (int k = 0; k < 2; k++) for (int m = 0; m < 3; m++) begin
			th = (m == 2) ? rnd() : 8'hFF;
			rst();
			wr(`GPT_ADDR_TIMER01_MODE_CONFIG, 8'(m << (4 * k)));
			wr(8'(`GPT_ADDR_TL0 + k), 8'hFE);
			wr(8'(`GPT_ADDR_TH0 + k), th);
			wr(`GPT_ADDR_TCON, 8'(8'h10 << (2 * k)));
			wait_irq(k, 40, 1);
			wr(`GPT_ADDR_TCON, 8'h00);
			rc(8'(`GPT_ADDR_TH0 + k), exp_hi(m, th));
			rd(8'(`GPT_ADDR_TL0 + k), v);
			if (m == 0) chk({5'h0, v[7:5]}, 8'h07);
		end
		rst();
		wr(`GPT_ADDR_TIMER01_MODE_CONFIG, 8'h30);
		wr(`GPT_ADDR_TL1, 8'hFE);
		wr(`GPT_ADDR_TCON, 8'h40);
		wait_irq(1, 30, 0);
		rc(`GPT_ADDR_TL1, 8'hFE);
		rst();
		wr(`GPT_ADDR_TIMER01_MODE_CONFIG, 8'h03);
		wr(`GPT_ADDR_TL0, 8'hFE);
		wr(`GPT_ADDR_TH0, 8'hFE);
		wr(`GPT_ADDR_TCON, 8'h10);
		wait_irq(0, 40, 1);
		wait_irq(1, 20, 0);
		rc(`GPT_ADDR_TH0, 8'hFE);
		wr(`GPT_ADDR_TCON, 8'h50);
		wait_irq(1, 40, 1);
		done("modes");
		for (int p = 0; p < 2; p++) begin
			rst();
			pol0 = p[0];
			irq0 = !p[0];
			wr(`GPT_ADDR_TIMER01_MODE_CONFIG, 8'h09);
			wr(`GPT_ADDR_TL0, 8'hFE);
			wr(`GPT_ADDR_TH0, 8'hFF);
			wr(`GPT_ADDR_TCON, 8'h10);
			wait_irq(0, 30, 0);
			irq0 = p[0];
			wait_irq(0, 40, 1);
		end
		rst();
		wr(`GPT_ADDR_TIMER01_MODE_CONFIG, 8'h05);
		wr(`GPT_ADDR_TL0, 8'hFD);
		wr(`GPT_ADDR_TH0, 8'hFF);
		wr(`GPT_ADDR_TCON, 8'h10);
		wait_irq(0, 20, 0);
		repeat (2) i_gpt_pins_model.pulse(0);
		wait_irq(0, 8, 0);
		i_gpt_pins_model.pulse(0);
		wait_irq(0, 10, 1);
		done("gate and pin");
		rst();
		wr(`GPT_ADDR_T2RLL, 8'h34);
		wr(`GPT_ADDR_T2RLH, 8'h12);
		wr(`GPT_ADDR_T2L, 8'hFE);
		wr(`GPT_ADDR_T2H, 8'hFF);
		wr(`GPT_ADDR_T2CTRL, 8'h04);
		wait_irq(2, 40, 1);
		wr(`GPT_ADDR_T2CTRL, 8'h80);
		rc(`GPT_ADDR_T2H, 8'h12);
		rd(`GPT_ADDR_T2CTRL, v);
		chk({7'h0, v[7]}, 8'h01);
		for (int len = 0; len < 2; len++) begin
			rst();
			wr(`GPT_ADDR_T2L, 8'hFE);
			wr(`GPT_ADDR_T2CTRL, 8'(8'h04 | (len << 5)));
			wait_irq(2, 30, len[0]);
		end
		rst();
		wr(`GPT_ADDR_T2RLL, 8'h40);
		wr(`GPT_ADDR_T2RLH, 8'h80);
		wr(`GPT_ADDR_T2L, 8'hFE);
		wr(`GPT_ADDR_T2H, 8'hFE);
		wr(`GPT_ADDR_T2CTRL, 8'h08);
		wait_irq(2, 30, 0);
		rd(`GPT_ADDR_T2CTRL, v);
		chk(v & 8'hC0, 8'h40);
		rc(`GPT_ADDR_T2H, 8'hFE);
		rd(`GPT_ADDR_T2L, v);
		chk(v & 8'hC0, 8'h40);
		wr(`GPT_ADDR_T2CTRL, 8'h0C);
		wait_irq(2, 30, 1);
		rd(`GPT_ADDR_T2H, v);
		chk(v & 8'hC0, 8'h80);
		done("timer 2");
		rst();
		t2ie = 0;
		wr(`GPT_ADDR_T2H, 8'h55);
		wr(`GPT_ADDR_T2CTRL, 8'h04);
		i_gpt_pins_model.pulse(2);
		rc(`GPT_ADDR_T2RLH, 8'h00);
		wr(`GPT_ADDR_T2CTRL, 8'h14);
		i_gpt_pins_model.pulse(2);
		rd(`GPT_ADDR_T2CTRL, v);
		chk({7'h0, v[7]}, 8'h01);
		rc(`GPT_ADDR_T2RLH, 8'h55);
		wait_irq(2, 10, 0);
		done("capture");
		wrap_up();
	end
endmodule // tb
`default_nettype wire
